// >>> logic/ddr_pkg.sv
/*
  ddr_pkg: shared constants, command encodings and carrier types for the ddr access block.
  assumes: one system clock samples the slow link clock; latency counts are in link clock cycles, burst lengths in words.
*/
package ddr_pkg;

  localparam int BANK_W = 3;
  localparam int ROW_W  = 14;
  localparam int COL_W  = 10;
  localparam int ADDR_W = 14;
  localparam int DQ_W   = 16;
  localparam int BYTE_W = 8;
  localparam int NBANK  = 8;
  localparam int WORDS  = 1024;

  localparam int AP_BIT = 10;

  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [3:0] CMD_ACT  = 4'h3;
  localparam logic [3:0] CMD_RD   = 4'h5;
  localparam logic [3:0] CMD_WR   = 4'h4;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_LMR  = 4'h0;
  localparam logic [3:0] CMD_DES  = 4'h8;

  localparam logic [3:0] BL4_CODE = 4'h4;
  localparam logic [3:0] BL8_CODE = 4'h8;
  localparam int         BL_DEFAULT = 4;
  localparam logic       SEQ_DEFAULT = 1'b0;
  localparam int         LAT_DEFAULT = 3;
  localparam int         MODE_BL_POS = 0;
  localparam int         MODE_BT_POS = 3;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } ddr_cmd_type;

  typedef struct packed {
    logic [DQ_W-1:0] dq;
    logic [1:0]      strobe;
    logic [1:0]      mask;
  } ddr_data_type;

  typedef enum logic [2:0] {
    DDR_IDLE  = 3'b000,
    DDR_READ  = 3'b001,
    DDR_WRITE = 3'b011,
    DDR_SREF  = 3'b010,
    DDR_PDN   = 3'b110
  } ddr_state_type;

endpackage : ddr_pkg

// >>> logic/ddr_sync.sv
/*
  ddr_sync: two-flop synchroniser for a bundle of pin inputs.
  assumes: inputs are asynchronous to mclk; nothing reads the first stage.
*/
`timescale 1ns/1ps
module ddr_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q      = stage1;
    if (sys_rst) begin
      next_stage1 = '0;
      next_q      = '0;
    end
  end

  always_ff @(posedge mclk) begin
    stage1 <= next_stage1;
    q      <= next_q;
  end
endmodule : ddr_sync

// >>> logic/ddr_access.sv
/*
  ddr_access: command decode, bank/row tracking, burst engine and strobe/data lanes of a
  x16 double-data-rate memory device, modelled on one fast system clock.
  assumes: true_clock/complement_clock, strobes and commands arrive from the controller as
  slow pins; mclk samples them through two flops and finds their edges.
*/
// Behaviour
// - commands sampled on each true clock rise
// - rise means true high, complement low
// - write data captured on both strobe edges
// - read data launched on both edges
// - device drives strobe only during reads
// - read strobe edges aligned with data
// - one half-clock transfer per core word
// - two data words per clock cycle
// - low byte low strobe/mask, high likewise
// - activate selects bank and row
// - read/write selects bank and column
// - burst of four or eight, programmed order
// - eight-beat burst cut by same-kind command
// - auto precharge closes row after burst
// - self refresh and power-down modes
// - behaviour assumes delay-locked loop enabled
// - address ten: auto precharge or all banks
`timescale 1ns/1ps
module ddr_access #(
  parameter int READ_LAT = ddr_pkg::LAT_DEFAULT
) (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  true_clock,
  input  wire logic                  complement_clock,
  input  wire ddr_pkg::ddr_cmd_type  cmd_in,
  input  wire ddr_pkg::ddr_data_type data_in,
  output ddr_pkg::ddr_data_type      data_out,
  output logic [1:0]                 strobe_oe_n,
  output logic                       dq_oe_n,
  output logic [ddr_pkg::NBANK-1:0]  bank_open,
  output logic                       self_refresh,
  output logic                       power_down
);
  import ddr_pkg::*;

  localparam int CMD_BITS = $bits(ddr_cmd_type);
  localparam int DAT_BITS = $bits(ddr_data_type);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge finding

  logic [1:0]   clk_s;
  ddr_cmd_type  cmd_s;
  ddr_data_type din_s;
  logic [1:0]   clk_d;
  logic [1:0]   stb_d;

  ddr_sync #(.W(2)) u_sync_clk (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d       ({true_clock, complement_clock}),
    .q       (clk_s)
  );
  ddr_sync #(.W(CMD_BITS)) u_sync_cmd (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d       (cmd_in),
    .q       (cmd_s)
  );
  ddr_sync #(.W(DAT_BITS)) u_sync_dat (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d       (data_in),
    .q       (din_s)
  );

  logic ck_rise;
  logic ck_fall;
  // differential crossing: true goes high while complement goes low
  assign ck_rise = (clk_s == 2'b10) && (clk_d == 2'b01);
  assign ck_fall = (clk_s == 2'b01) && (clk_d == 2'b10);

  logic [1:0] stb_edge;
  assign stb_edge = din_s.strobe ^ stb_d;

  ////////////////////////////////////////////////////////////////////////////////
  // command decode

  function automatic logic [3:0] cmd_code(input ddr_cmd_type c);
    if (c.cs_n) begin
      cmd_code = CMD_DES;
    end else begin
      cmd_code = {1'b0, c.ras_n, c.cas_n, c.we_n};
    end
  endfunction : cmd_code

  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [2:0] beat,
                                                 input logic bl8,
                                                 input logic ilv);
    logic [2:0] low;
    low = ilv ? (start[2:0] ^ beat) : (start[2:0] + beat);
    if (!bl8) begin
      low[2] = start[2];
    end
    burst_col = {start[COL_W-1:3], low};
  endfunction : burst_col

  logic [3:0] cmd;
  assign cmd = ck_rise ? cmd_code(cmd_s) : CMD_DES;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [DQ_W-1:0] mem [0:NBANK*WORDS-1];

  ddr_state_type   state,      next_state;
  logic [NBANK-1:0] next_bank_open;
  logic [ROW_W-1:0] open_row   [0:NBANK-1];
  logic             bl8,       next_bl8;
  logic             ilv,       next_ilv;
  logic [BANK_W-1:0] cur_bank, next_cur_bank;
  logic [COL_W-1:0] cur_col,   next_cur_col;
  logic             cur_ap,    next_cur_ap;
  logic [2:0]       beat,      next_beat;
  logic [3:0]       lat,       next_lat;
  logic             active,    next_active;
  logic             ph,        next_ph;
  ddr_data_type     next_data_out;
  logic [1:0]       next_strobe_oe_n;
  logic             next_dq_oe_n;
  logic             next_self_refresh;
  logic             next_power_down;
  logic             wr_en;
  logic [12:0]      wr_addr;
  logic [DQ_W-1:0]  wr_data;
  logic [DQ_W-1:0]  wr_bits;
  logic [2:0]       last_beat;
  logic [12:0]      rd_addr;
  logic             rd_go;

  assign last_beat = bl8 ? 3'h7 : 3'h3;
  // latency spent: this rise already carries the first word
  assign rd_go     = ck_rise && !active && (lat == 4'h0);
  assign rd_addr   = {cur_bank, burst_col(cur_col, beat, bl8, ilv)};

  always_comb begin
    next_state        = state;
    next_bank_open    = bank_open;
    next_bl8          = bl8;
    next_ilv          = ilv;
    next_cur_bank     = cur_bank;
    next_cur_col      = cur_col;
    next_cur_ap       = cur_ap;
    next_beat         = beat;
    next_lat          = lat;
    next_active       = active;
    next_ph           = ph;
    next_data_out     = data_out;
    next_strobe_oe_n  = strobe_oe_n;
    next_dq_oe_n      = dq_oe_n;
    next_self_refresh = self_refresh;
    next_power_down   = power_down;
    wr_en             = 1'b0;
    wr_addr           = rd_addr;
    wr_data           = mem[rd_addr];
    wr_bits           = wr_data;

    // new same-kind command restarts the burst at its own column
    if ((cmd == CMD_RD) || (cmd == CMD_WR)) begin
      next_state    = (cmd == CMD_RD) ? DDR_READ : DDR_WRITE;
      next_cur_bank = cmd_s.bank;
      next_cur_col  = cmd_s.addr[COL_W-1:0];
      next_cur_ap   = cmd_s.addr[AP_BIT];
      next_beat     = 3'h0;
      next_lat      = 4'(READ_LAT);
      next_active   = 1'b0;
      next_ph       = 1'b0;
    end else begin
      case (cmd)
        CMD_ACT: begin
          next_bank_open[cmd_s.bank] = 1'b1;
        end
        CMD_PRE: begin
          if (cmd_s.addr[AP_BIT]) begin
            next_bank_open = '0;
          end else begin
            next_bank_open[cmd_s.bank] = 1'b0;
          end
        end
        CMD_LMR: begin
          next_bl8 = (cmd_s.addr[MODE_BL_POS+:4] == BL8_CODE);
          next_ilv = cmd_s.addr[MODE_BT_POS];
        end
        CMD_REF: begin
          if (!cmd_s.cke) begin
            next_self_refresh = 1'b1;
            next_state        = DDR_SREF;
          end
        end
        CMD_NOP, CMD_DES: begin
          if (ck_rise && (state == DDR_IDLE) && !cmd_s.cke) begin
            next_power_down = 1'b1;
            next_state      = DDR_PDN;
          end
        end
        default: begin
        end
      endcase
    end

    case (state)
      DDR_SREF, DDR_PDN: begin
        if (ck_rise && cmd_s.cke) begin
          next_state        = DDR_IDLE;
          next_self_refresh = 1'b0;
          next_power_down   = 1'b0;
        end
      end
      DDR_READ: begin
        if (ck_rise && !active && (cmd != CMD_RD)) begin
          if (lat == 4'h0) begin
            next_active = 1'b1;
          end else begin
            next_lat = lat - 4'h1;
          end
        end
        // each clock half carries one word, data changes with strobe
        if ((active || rd_go) && (ck_rise || ck_fall) && (cmd != CMD_RD)) begin
          if (ph) begin
            // edge after the last word closes the burst
            next_active = 1'b0;
            next_ph     = 1'b0;
            next_state  = DDR_IDLE;
            if (cur_ap) begin
              next_bank_open[cur_bank] = 1'b0;
            end
          end else begin
            next_data_out.dq     = mem[rd_addr];
            next_data_out.strobe = ck_rise ? 2'b11 : 2'b00;
            next_data_out.mask   = 2'b00;
            next_strobe_oe_n     = 2'b00;
            next_dq_oe_n         = 1'b0;
            if (beat == last_beat) begin
              next_ph = 1'b1;
            end else begin
              next_beat = beat + 3'h1;
            end
          end
        end
      end
      DDR_WRITE: begin
        // capture on every strobe transition, rising or falling
        if (stb_edge[0] || stb_edge[1]) begin
          wr_en = 1'b1;
          // each byte lane obeys its own mask
          if (stb_edge[0] && !din_s.mask[0]) begin
            wr_bits[BYTE_W-1:0] = din_s.dq[BYTE_W-1:0];
          end
          if (stb_edge[1] && !din_s.mask[1]) begin
            wr_bits[DQ_W-1:BYTE_W] = din_s.dq[DQ_W-1:BYTE_W];
          end
          if (beat == last_beat) begin
            next_state = DDR_IDLE;
            if (cur_ap) begin
              next_bank_open[cur_bank] = 1'b0;
            end
          end else begin
            next_beat = beat + 3'h1;
          end
        end
      end
      default: begin
      end
    endcase

    if (next_state != DDR_READ) begin
      next_strobe_oe_n = 2'b11;
      next_dq_oe_n     = 1'b1;
      next_data_out    = '0;
    end

    if (sys_rst) begin
      next_state        = DDR_IDLE;
      next_bank_open    = '0;
      next_bl8          = (BL_DEFAULT == 8);
      next_ilv          = SEQ_DEFAULT;
      next_cur_bank     = '0;
      next_cur_col      = '0;
      next_cur_ap       = 1'b0;
      next_beat         = 3'h0;
      next_lat          = 4'h0;
      next_active       = 1'b0;
      next_ph           = 1'b0;
      next_data_out     = '0;
      next_strobe_oe_n  = 2'b11;
      next_dq_oe_n      = 1'b1;
      next_self_refresh = 1'b0;
      next_power_down   = 1'b0;
      wr_en             = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    clk_d        <= sys_rst ? 2'b00 : clk_s;
    stb_d        <= sys_rst ? 2'b00 : din_s.strobe;
    state        <= next_state;
    bank_open    <= next_bank_open;
    bl8          <= next_bl8;
    ilv          <= next_ilv;
    cur_bank     <= next_cur_bank;
    cur_col      <= next_cur_col;
    cur_ap       <= next_cur_ap;
    beat         <= next_beat;
    lat          <= next_lat;
    active       <= next_active;
    ph           <= next_ph;
    data_out     <= next_data_out;
    strobe_oe_n  <= next_strobe_oe_n;
    dq_oe_n      <= next_dq_oe_n;
    self_refresh <= next_self_refresh;
    power_down   <= next_power_down;
    if (wr_en) begin
      mem[wr_addr] <= wr_bits;
    end
    if ((cmd == CMD_ACT) && !sys_rst) begin
      open_row[cmd_s.bank] <= cmd_s.addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_read_cmd;
    cmd == CMD_RD;
  endsequence

  sequence s_strobe_driven;
    strobe_oe_n == 2'b00;
  endsequence

  a_strobe_only_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (strobe_oe_n != 2'b11) |-> (state == DDR_READ))
    else $error("strobe driven outside read");

  a_read_drives_strobe: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == DDR_READ && active && !ph && ck_rise && cmd != CMD_RD) |=> s_strobe_driven)
    else $error("read burst strobe not driven");

  a_read_enters: assert property (@(posedge mclk) disable iff (sys_rst)
    s_read_cmd |=> (state == DDR_READ && beat == 3'h0 && !active))
    else $error("read command not taken");

  a_write_enters: assert property (@(posedge mclk) disable iff (sys_rst)
    (cmd == CMD_WR) |=> (state == DDR_WRITE && beat == 3'h0))
    else $error("write command not taken");

  a_act_opens: assert property (@(posedge mclk) disable iff (sys_rst)
    (cmd == CMD_ACT) |=> bank_open[$past(cmd_s.bank)])
    else $error("activate did not open bank");

  a_pre_all: assert property (@(posedge mclk) disable iff (sys_rst)
    (cmd == CMD_PRE && cmd_s.addr[AP_BIT]) |=> (bank_open == '0))
    else $error("precharge all left bank open");

  a_cmd_on_rise: assert property (@(posedge mclk) disable iff (sys_rst)
    (cmd != CMD_DES) |-> ck_rise)
    else $error("command taken off clock rise");

  a_strobe_phase: assert property (@(posedge mclk) disable iff (sys_rst)
    (state == DDR_READ && active && ck_fall) |=> (data_out.strobe == 2'b00))
    else $error("read strobe not aligned to fall");

  a_beat_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    (!bl8 && state != DDR_IDLE) |-> (beat <= 3'h3))
    else $error("four beat burst overran");

  a_sref_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    self_refresh |-> (state == DDR_SREF))
    else $error("self refresh flag without state");

endmodule : ddr_access

// >>> testbench/ddr_ctrl_model.sv
/* ddr_ctrl_model: controller side of the link: clock pair, commands, write bursts.
   assumes: its tasks are called from one bench process, one at a time. */
`timescale 1ns/1ps
module ddr_ctrl_model (
  output logic                  true_clock,
  output logic                  complement_clock,
  output ddr_pkg::ddr_cmd_type  cmd,
  output ddr_pkg::ddr_data_type wdata
);
  import ddr_pkg::*;
  ////////////////////////////////////////////////////////////
  initial begin
    true_clock = 1'b0;
    cmd = {CMD_NOP, 1'b1, 3'h0, 14'h0};
    wdata = '0;
    #7;
    forever #100 true_clock = ~true_clock;
  end
  assign complement_clock = ~true_clock;
  ////////////////////////////////////////////////////////////
  // command stands across exactly one rising edge
  task automatic issue(input logic [3:0] op, input logic ke, input logic [2:0] b,
                       input logic [13:0] a);
    @(negedge true_clock);
    cmd <= {op, ke, b, a};
    @(negedge true_clock);
    cmd <= {CMD_NOP, ke, b, a};
  endtask : issue
  // command that never meets a rising edge
  task automatic stray(input logic [2:0] b);
    @(negedge true_clock);
    #20 cmd <= {CMD_ACT, 1'b1, b, 14'h0};
    #40 cmd <= {CMD_NOP, 1'b1, b, 14'h0};
  endtask : stray
  // one word per half clock from the next rise, strobe in mid eye
  task automatic beats(input logic [15:0] w[8], input logic [1:0] m[8], input int n);
    @(posedge true_clock);
    for (int i = 0; i < n; i++) begin
      if (i > 0) @(true_clock);
      wdata.dq   <= w[i];
      wdata.mask <= m[i];
      #50 wdata.strobe <= ~wdata.strobe;
    end
    // released: dq stops showing the last word, strobes rest low
    #50 wdata.dq <= ~wdata.dq;
  endtask : beats
endmodule : ddr_ctrl_model

// >>> testbench/ddr_access_tb.sv
/* ddr_access_tb: self-checking bench for ddr_access driven by a controller model.
   assumes: each read word shows as a strobe change while dq_oe_n is low. */
`timescale 1ns/1ps
module ddr_access_tb;
  import ddr_pkg::*;
  logic             mclk;
  logic             sys_rst;
  logic             true_clock;
  logic             complement_clock;
  ddr_cmd_type      cmd_in;
  ddr_data_type     data_in;
  ddr_data_type     data_out;
  logic [1:0]       strobe_oe_n;
  logic             dq_oe_n;
  logic [NBANK-1:0] bank_open;
  logic             self_refresh;
  logic             power_down;
  int               failures;
  int               comparisons;
  logic [15:0]      mem[int];
  logic [15:0]      exp_q[$];
  logic             bl8;
  logic             ilv;
  logic             prev;
  logic             s0;
  logic [3:0]       modes[3] = '{4'h4, 4'hc, 4'h8};
  logic [3:0]       lp_op[4] = '{CMD_REF, CMD_NOP, CMD_NOP, CMD_NOP};
  logic             lp_ke[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [1:0]       lp_exp[4] = '{2'b10, 2'b00, 2'b01, 2'b00};

  ddr_access #(.READ_LAT(LAT_DEFAULT)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .true_clock(true_clock),
    .complement_clock(complement_clock), .cmd_in(cmd_in), .data_in(data_in),
    .data_out(data_out), .strobe_oe_n(strobe_oe_n), .dq_oe_n(dq_oe_n),
    .bank_open(bank_open), .self_refresh(self_refresh), .power_down(power_down));
  ddr_ctrl_model ctl (.true_clock(true_clock), .complement_clock(complement_clock),
    .cmd(cmd_in), .wdata(data_in));
  assign s0 = data_out.strobe[0];
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // waits for reads to drain, then for the pin-to-decode latency
  task automatic settle();
    for (int i = 0; i <= 400; i++) begin
      if (i == 400) begin
        failures++;
        summarize();
      end
      if (dq_oe_n === 1'b1 && exp_q.size() == 0) break;
      @(negedge mclk);
    end
    repeat (4) @(negedge mclk);
  endtask : settle

  function automatic int addr_of(input logic [2:0] b, input logic [9:0] c, input int i);
    logic [9:0] k;
    k = ilv ? (c ^ 10'(i)) : (c + 10'(i));
    k = bl8 ? {c[9:3], k[2:0]} : {c[9:2], k[1:0]};
    return int'({b, k});
  endfunction : addr_of

  task automatic wr(input logic [2:0] b, input logic [9:0] c, input int n);
    logic [15:0] w[8];
    logic [1:0]  m[8];
    int          k;
    for (int i = 0; i < 8; i++) begin
      k = addr_of(b, c, i);
      w[i] = 16'($urandom);
      m[i] = mem.exists(k) ? 2'($urandom & $urandom) : 2'b00;
      if (i < n && !m[i][0]) mem[k][7:0] = w[i][7:0];
      if (i < n && !m[i][1]) mem[k][15:8] = w[i][15:8];
    end
    ctl.issue(CMD_WR, 1'b1, b, {4'h0, c});
    ctl.beats(w, m, n);
    check("write oe_n", {13'h0, strobe_oe_n, dq_oe_n}, 16'h0007);
  endtask : wr

  task automatic rd(input logic [2:0] b, input logic [9:0] c, input logic ap, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(mem[addr_of(b, c, i)]);
    ctl.issue(CMD_RD, 1'b1, b, {3'h0, ap, c});
  endtask : rd
  ////////////////////////////////////////////////////////////
  // every strobe change during a read hands over one word
  always @(negedge mclk) begin
    if (dq_oe_n === 1'b0 && s0 !== prev) begin
      if (exp_q.size() == 0)
        check("extra beat", 16'h0001, 16'h0000);
      else
        check("read dq", data_out.dq, exp_q.pop_front());
      check("rd lanes", {12'h0, strobe_oe_n, data_out.strobe}, {14'h0, s0, s0});
    end
    prev <= (dq_oe_n === 1'b0) ? s0 : 1'b0;
  end

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    logic [2:0] b;
    logic [9:0] c;
    failures = 0;
    comparisons = 0;
    prev = 1'b0;
    bl8 = 1'b0;
    ilv = 1'b0;
    sys_rst = 1'b1;
    void'($urandom(32'hde7b_0066));
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    check("reset dq", data_out.dq, 16'h0000);
    check("reset", {3'h0, self_refresh, power_down, strobe_oe_n, dq_oe_n, bank_open}, 16'h0700);
    foreach (modes[j]) begin
      bl8 = (modes[j] == BL8_CODE);
      ilv = modes[j][3];
      b = 3'($urandom);
      c = 10'($urandom);
      ctl.issue(CMD_LMR, 1'b1, 3'h0, {10'h0, modes[j]});
      ctl.issue(CMD_ACT, 1'b1, b, 14'($urandom));
      settle();
      check("act", {8'h0, bank_open}, {8'h0, 8'h01 << b});
      wr(b, c, bl8 ? 8 : 4);
      wr(b, c + 10'd1, bl8 ? 8 : 4);
      rd(b, c + 10'd1, 1'b1, bl8 ? 8 : 4);
      settle();
      check("auto pre", {8'h0, bank_open}, 16'h0000);
    end
    c = {7'($urandom), 3'h0};
    ctl.issue(CMD_ACT, 1'b1, 3'd5, 14'h0);
    wr(3'd5, c, 8);
    wr(3'd5, c + 10'd3, 4);
    wr(3'd5, c + 10'd8, 8);
    rd(3'd5, c, 1'b0, 8);
    settle();
    // cut during its latency, so it hands over no word
    rd(3'd5, c + 10'd8, 1'b0, 0);
    rd(3'd5, c, 1'b1, 8);
    settle();
    ctl.issue(CMD_ACT, 1'b1, 3'd1, 14'h0);
    ctl.issue(CMD_ACT, 1'b1, 3'd6, 14'h0);
    ctl.stray(3'd3);
    settle();
    check("open pair", {8'h0, bank_open}, 16'h0042);
    ctl.issue(CMD_PRE, 1'b1, 3'd1, 14'h0000);
    settle();
    check("pre one", {8'h0, bank_open}, 16'h0040);
    ctl.issue(CMD_PRE, 1'b1, 3'd0, 14'h0400);
    settle();
    check("pre all", {8'h0, bank_open}, 16'h0000);
    foreach (lp_op[j]) begin
      ctl.issue(lp_op[j], lp_ke[j], 3'h0, 14'h0000);
      settle();
      check("low power", {14'h0, self_refresh, power_down}, {14'h0, lp_exp[j]});
    end
    summarize();
  end
endmodule : ddr_access_tb
